// ---- src/tcd_top.v ----
// Operation
// - packet 24 to extension or page memory
// - displayed row 24 from page or extension
// - auto frame off while video shown
// - inhibit bit stops rolling header writes
// - status-row-only shows row 24 alone
// - inventory page captured into block 8
// - extension packet inhibit stops their writes
// - eight-bit mode skips checks rows 0-24
`timescale 1ns/1ps
`default_nettype none
`include "tcd_map.vh"

module tcd_top (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata_ff,
    output reg hreadyout_ff,
    output reg hresp_ff,
    input wire pkt_valid,
    input wire [4:0] pkt_num,
    input wire pkt_check_ok,
    input wire pkt_header_roll,
    input wire pkt_inventory,
    input wire pkt_prog_label,
    output wire wr_page_ff,
    output wire wr_ext_ff,
    output wire wr_block8_ff,
    output wire wr_label_ff,
    output wire [4:0] wr_row_ff,
    input wire disp_row_valid,
    input wire [4:0] disp_row,
    input wire disp_text_on,
    input wire disp_video_on,
    output wire row_show_ff,
    output wire row_from_ext_ff,
    output wire frame_ff
);

// ------------------------------------------------------------
// helpers
// ------------------------------------------------------------
function hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
        hit = (addr == ofs);
    end
endfunction

function [15:0] sat_inc;
    input [15:0] v;
    begin
        sat_inc = (v == `TCD_CNT_MAX) ? v : v + 16'h0001;
    end
endfunction

// ------------------------------------------------------------
// bus address phase
// ------------------------------------------------------------
reg wr_pend_ff;
reg [11:0] wr_addr_ff;
wire take = hsel & hready & htrans[1];
wire take_rd = take & ~hwrite;
wire [11:0] a_addr = haddr[11:0];

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend_ff <= 1'b0;
        wr_addr_ff <= 12'h000;
    end else begin
        wr_pend_ff <= take & hwrite;
        wr_addr_ff <= a_addr;
    end
end

// ------------------------------------------------------------
// control registers
// ------------------------------------------------------------
reg [7:0] ctrl0_ff;
reg [7:0] ctrl1_ff;
reg [7:0] nxt_ctrl0;
reg [7:0] nxt_ctrl1;
wire wr_c0 = wr_pend_ff & hit(wr_addr_ff, `TCD_OFS_CTRL0);
wire wr_c1 = wr_pend_ff & hit(wr_addr_ff, `TCD_OFS_CTRL1);
wire wr_acc = wr_pend_ff & hit(wr_addr_ff, `TCD_OFS_ACC_CNT);
wire wr_drop = wr_pend_ff & hit(wr_addr_ff, `TCD_OFS_DROP_CNT);

always @* begin
    nxt_ctrl0 = wr_c0 ? hwdata[7:0] : ctrl0_ff;
    nxt_ctrl1 = wr_c1 ? (hwdata[7:0] & `TCD_C1_MASK) : ctrl1_ff;
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ctrl0_ff <= `TCD_CTRL0_RST;
        ctrl1_ff <= `TCD_CTRL1_RST;
    end else begin
        ctrl0_ff <= nxt_ctrl0;
        ctrl1_ff <= nxt_ctrl1;
    end
end

// ------------------------------------------------------------
// acquisition steering
// ------------------------------------------------------------
wire drop_pulse;

tcd_capture u_capture (
    .hclk(hclk),
    .hresetn(hresetn),
    .pkt_valid(pkt_valid),
    .pkt_num(pkt_num),
    .pkt_check_ok(pkt_check_ok),
    .pkt_header_roll(pkt_header_roll),
    .pkt_inventory(pkt_inventory),
    .pkt_prog_label(pkt_prog_label),
    .store_sel(ctrl0_ff[`TCD_C0_STORE_SEL]),
    .hdr_inhibit(ctrl0_ff[`TCD_C0_HDR_INHIBIT]),
    .inventory_capture_on(ctrl0_ff[`TCD_C0_INVENTORY_CAPTURE]),
    .prog_label_on(ctrl0_ff[`TCD_C0_PROG_LABEL]),
    .ext_inhibit(ctrl1_ff[`TCD_C1_EXT_INHIBIT]),
    .eight_bit(ctrl1_ff[`TCD_C1_EIGHT_BIT]),
    .wr_page_ff(wr_page_ff),
    .wr_ext_ff(wr_ext_ff),
    .wr_block8_ff(wr_block8_ff),
    .wr_label_ff(wr_label_ff),
    .wr_row_ff(wr_row_ff),
    .drop_ff(drop_pulse)
);

// ------------------------------------------------------------
// display selection
// ------------------------------------------------------------
tcd_display u_display (
    .hclk(hclk),
    .hresetn(hresetn),
    .disp_row_valid(disp_row_valid),
    .disp_row(disp_row),
    .disp_text_on(disp_text_on),
    .disp_video_on(disp_video_on),
    .disp_src(ctrl0_ff[`TCD_C0_DISP_SRC]),
    .auto_frame(ctrl0_ff[`TCD_C0_AUTO_FRAME]),
    .status_only(ctrl0_ff[`TCD_C0_STATUS_ONLY]),
    .frame_off(ctrl0_ff[`TCD_C0_FRAME_OFF]),
    .row_show_ff(row_show_ff),
    .row_from_ext_ff(row_from_ext_ff),
    .frame_ff(frame_ff)
);

// ------------------------------------------------------------
// statistics
// ------------------------------------------------------------
// counters saturate rather than wrap so a long unattended run is not misread
reg [15:0] acc_cnt_ff;
reg [15:0] drop_cnt_ff;
reg [15:0] nxt_acc;
reg [15:0] nxt_drop;
wire any_wr = wr_page_ff | wr_ext_ff | wr_block8_ff | wr_label_ff;

always @* begin
    nxt_acc = acc_cnt_ff;
    nxt_drop = drop_cnt_ff;
    // a count arriving with the clear is kept: set beats clear
    if (wr_acc) begin
        nxt_acc = any_wr ? 16'h0001 : 16'h0000;
    end else if (any_wr) begin
        nxt_acc = sat_inc(acc_cnt_ff);
    end
    if (wr_drop) begin
        nxt_drop = drop_pulse ? 16'h0001 : 16'h0000;
    end else if (drop_pulse) begin
        nxt_drop = sat_inc(drop_cnt_ff);
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        acc_cnt_ff <= 16'h0000;
        drop_cnt_ff <= 16'h0000;
    end else begin
        acc_cnt_ff <= nxt_acc;
        drop_cnt_ff <= nxt_drop;
    end
end

// ------------------------------------------------------------
// read data
// ------------------------------------------------------------
// next values are used so a read right behind a write sees the new data
reg [31:0] rd_mux;
wire [7:0] status_byte = {1'b0, frame_ff, row_from_ext_ff, row_show_ff,
                          wr_label_ff, wr_block8_ff, wr_ext_ff, wr_page_ff};

always @* begin
    rd_mux = 32'h0000_0000;
    if (hit(a_addr, `TCD_OFS_CTRL0)) begin
        rd_mux = {24'h000000, nxt_ctrl0};
    end else if (hit(a_addr, `TCD_OFS_CTRL1)) begin
        rd_mux = {24'h000000, nxt_ctrl1};
    end else if (hit(a_addr, `TCD_OFS_STATUS)) begin
        rd_mux = {24'h000000, status_byte};
    end else if (hit(a_addr, `TCD_OFS_ACC_CNT)) begin
        rd_mux = {16'h0000, nxt_acc};
    end else if (hit(a_addr, `TCD_OFS_DROP_CNT)) begin
        rd_mux = {16'h0000, nxt_drop};
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata_ff <= 32'h0000_0000;
        hreadyout_ff <= 1'b1;
        hresp_ff <= 1'b0;
    end else begin
        hrdata_ff <= take_rd ? rd_mux : 32'h0000_0000;
        hreadyout_ff <= 1'b1;
        hresp_ff <= 1'b0;
    end
end

endmodule
`default_nettype wire

// ---- src/tcd_map.vh ----
`ifndef TCD_MAP_VH
`define TCD_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TCD_OFS_CTRL0 12'h000
`define TCD_OFS_CTRL1 12'h004
`define TCD_OFS_STATUS 12'h008
`define TCD_OFS_ACC_CNT 12'h00c
`define TCD_OFS_DROP_CNT 12'h010

// ------------------------------------------------------------
// control zero fields
// ------------------------------------------------------------
`define TCD_C0_STORE_SEL 7
`define TCD_C0_DISP_SRC 6
`define TCD_C0_AUTO_FRAME 5
`define TCD_C0_HDR_INHIBIT 4
`define TCD_C0_STATUS_ONLY 3
`define TCD_C0_FRAME_OFF 2
`define TCD_C0_PROG_LABEL 1
`define TCD_C0_INVENTORY_CAPTURE 0

// ------------------------------------------------------------
// control one fields
// ------------------------------------------------------------
`define TCD_C1_EXT_INHIBIT 7
`define TCD_C1_EIGHT_BIT 6
`define TCD_C1_MASK 8'hc0

// ------------------------------------------------------------
// reset values and packet numbers
// ------------------------------------------------------------
`define TCD_CTRL0_RST 8'h00
`define TCD_CTRL1_RST 8'h00
`define TCD_ROW_STATUS 5'h18
`define TCD_CNT_MAX 16'hffff

`endif

// ---- src/tcd_capture.v ----
`timescale 1ns/1ps
`default_nettype none
`include "tcd_map.vh"

module tcd_capture (
    input wire hclk,
    input wire hresetn,
    input wire pkt_valid,
    input wire [4:0] pkt_num,
    input wire pkt_check_ok,
    input wire pkt_header_roll,
    input wire pkt_inventory,
    input wire pkt_prog_label,
    input wire store_sel,
    input wire hdr_inhibit,
    input wire inventory_capture_on,
    input wire prog_label_on,
    input wire ext_inhibit,
    input wire eight_bit,
    output reg wr_page_ff,
    output reg wr_ext_ff,
    output reg wr_block8_ff,
    output reg wr_label_ff,
    output reg [4:0] wr_row_ff,
    output reg drop_ff
);

// ------------------------------------------------------------
// write steering
// ------------------------------------------------------------
reg nxt_page;
reg nxt_ext;
reg nxt_blk8;
reg nxt_label;
reg ok;

always @* begin
    nxt_page = 1'b0;
    nxt_ext = 1'b0;
    nxt_blk8 = 1'b0;
    nxt_label = 1'b0;
    // rows 0..24 may bypass checking in eight-bit mode
    ok = pkt_check_ok | (eight_bit & (pkt_num <= `TCD_ROW_STATUS));
    if (pkt_valid && ok) begin
        if (pkt_prog_label) begin
            nxt_label = prog_label_on;
        end else if (pkt_inventory) begin
            nxt_blk8 = inventory_capture_on;
        end else if (pkt_header_roll) begin
            nxt_page = ~hdr_inhibit;
        end else if (pkt_num == `TCD_ROW_STATUS) begin
            nxt_page = store_sel;
            nxt_ext = ~store_sel & ~ext_inhibit;
        end else if (pkt_num > `TCD_ROW_STATUS) begin
            nxt_ext = ~ext_inhibit;
        end else begin
            nxt_page = 1'b1;
        end
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_page_ff <= 1'b0;
        wr_ext_ff <= 1'b0;
        wr_block8_ff <= 1'b0;
        wr_label_ff <= 1'b0;
        wr_row_ff <= 5'h00;
        drop_ff <= 1'b0;
    end else begin
        wr_page_ff <= nxt_page;
        wr_ext_ff <= nxt_ext;
        wr_block8_ff <= nxt_blk8;
        wr_label_ff <= nxt_label;
        wr_row_ff <= pkt_num;
        drop_ff <= pkt_valid & ~(nxt_page | nxt_ext | nxt_blk8 | nxt_label);
    end
end

endmodule
`default_nettype wire

// ---- src/tcd_display.v ----
`timescale 1ns/1ps
`default_nettype none
`include "tcd_map.vh"

module tcd_display (
    input wire hclk,
    input wire hresetn,
    input wire disp_row_valid,
    input wire [4:0] disp_row,
    input wire disp_text_on,
    input wire disp_video_on,
    input wire disp_src,
    input wire auto_frame,
    input wire status_only,
    input wire frame_off,
    output reg row_show_ff,
    output reg row_from_ext_ff,
    output reg frame_ff
);

wire is_status = (disp_row == `TCD_ROW_STATUS);

// ------------------------------------------------------------
// row selection and frame blanking
// ------------------------------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        row_show_ff <= 1'b0;
        row_from_ext_ff <= 1'b0;
        frame_ff <= 1'b0;
    end else begin
        row_show_ff <= disp_row_valid & (is_status | ~status_only);
        row_from_ext_ff <= disp_row_valid & is_status & disp_src;
        // forced low wins over everything else
        frame_ff <= disp_text_on & ~frame_off & ~(auto_frame & disp_video_on);
    end
end

endmodule
`default_nettype wire

// ---- test/tcd_top_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tcd_map.vh"
module tcd_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout_ff,
    input wire logic hresp_ff,
    input wire logic pkt_valid,
    input wire logic [4:0] pkt_num,
    input wire logic pkt_check_ok,
    input wire logic pkt_header_roll,
    input wire logic pkt_inventory,
    input wire logic pkt_prog_label,
    input wire logic wr_page_ff,
    input wire logic wr_ext_ff,
    input wire logic wr_block8_ff,
    input wire logic [4:0] wr_row_ff,
    input wire logic disp_row_valid,
    input wire logic [4:0] disp_row,
    input wire logic disp_video_on,
    input wire logic row_show_ff,
    input wire logic row_from_ext_ff,
    input wire logic frame_ff
);
// ----
// shadow of the control words, rebuilt from bus writes
// ----
logic wr_ph_ff;
logic [11:0] a_ff;
logic [7:0] c0_ff;
logic [7:0] c1_ff;
logic pk;
assign pk = pkt_valid && !pkt_prog_label && !pkt_inventory;
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_ph_ff <= 1'b0;
        a_ff <= 12'h000;
        c0_ff <= 8'h00;
        c1_ff <= 8'h00;
    end else begin
        wr_ph_ff <= hsel && hready && htrans[1] && hwrite;
        a_ff <= haddr[11:0];
        if (wr_ph_ff && a_ff == `TCD_OFS_CTRL0) c0_ff <= hwdata[7:0];
        if (wr_ph_ff && a_ff == `TCD_OFS_CTRL1) c1_ff <= hwdata[7:0] & 8'hc0;
    end
end
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
property p_okay; hreadyout_ff && !hresp_ff; endproperty
a_okay: assert property (p_okay) else $error("bus not ready or error");
property p_ext24; pk && pkt_check_ok && !pkt_header_roll && pkt_num == 5'h18 && !c0_ff[7] && !c1_ff[7]
    |=> wr_ext_ff && !wr_page_ff && wr_row_ff == 5'h18; endproperty
a_ext24: assert property (p_ext24) else $error("row 24 not to ext");
property p_pg24; pk && pkt_check_ok && !pkt_header_roll && pkt_num == 5'h18 && c0_ff[7]
    |=> wr_page_ff && !wr_ext_ff; endproperty
a_pg24: assert property (p_pg24) else $error("row 24 not to page");
property p_src; disp_row_valid && disp_row == 5'h18 |=> row_from_ext_ff == $past(c0_ff[6]); endproperty
a_src: assert property (p_src) else $error("row 24 source wrong");
property p_auto; disp_video_on && c0_ff[5] |=> !frame_ff; endproperty
a_auto: assert property (p_auto) else $error("frame on with video");
property p_hdr; pk && pkt_header_roll && c0_ff[4] |=> !wr_page_ff && !wr_ext_ff; endproperty
a_hdr: assert property (p_hdr) else $error("header written");
property p_stat; disp_row_valid && c0_ff[3] && disp_row != 5'h18 |=> !row_show_ff; endproperty
a_stat: assert property (p_stat) else $error("row shown");
property p_inv; pkt_valid && pkt_check_ok && pkt_inventory && !pkt_prog_label && c0_ff[0] |=> wr_block8_ff;
endproperty
a_inv: assert property (p_inv) else $error("inventory lost");
property p_xin; pkt_valid && c1_ff[7] && pkt_num > 5'h18 |=> !wr_ext_ff; endproperty
a_xin: assert property (p_xin) else $error("ext written");
property p_eight; pk && !pkt_header_roll && !pkt_check_ok && c1_ff[6] && pkt_num < 5'h18 |=> wr_page_ff;
endproperty
a_eight: assert property (p_eight) else $error("unchecked packet lost");
c_ext: cover property (pk && pkt_check_ok && !pkt_header_roll && pkt_num == 5'h18 && !c0_ff[7] && !c1_ff[7]
    ##1 wr_ext_ff);
c_hdr: cover property (pk && pkt_header_roll && c0_ff[4]);
c_auto: cover property (disp_video_on && c0_ff[5]);
endmodule
bind tcd_top tcd_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout_ff,
    .hresp_ff, .pkt_valid, .pkt_num, .pkt_check_ok, .pkt_header_roll, .pkt_inventory, .pkt_prog_label, .wr_page_ff,
    .wr_ext_ff, .wr_block8_ff, .wr_row_ff, .disp_row_valid, .disp_row, .disp_video_on, .row_show_ff,
    .row_from_ext_ff, .frame_ff);
`default_nettype wire

// ---- test/tcd_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tcd_map.vh"
module tcd_top_tb;
logic hclk, hresetn, hsel, hwrite, hready;
logic [31:0] haddr, hwdata, hrdata_ff;
logic [1:0] htrans;
logic hreadyout_ff, hresp_ff, pkt_valid, pkt_check_ok, pkt_header_roll, pkt_inventory, pkt_prog_label;
logic [4:0] pkt_num, wr_row_ff, disp_row;
logic wr_page_ff, wr_ext_ff, wr_block8_ff, wr_label_ff, disp_row_valid, disp_text_on, disp_video_on;
logic row_show_ff, row_from_ext_ff, frame_ff;
logic [15:0] lfsr;
logic [7:0] c0, c1;
logic [31:0] rd;
logic [2:0] disp_m;
int bad_count, tests_run, acc_m, drop_m;
assign hready = hreadyout_ff;
tcd_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata_ff,
    .hreadyout_ff, .hresp_ff, .pkt_valid, .pkt_num, .pkt_check_ok, .pkt_header_roll, .pkt_inventory,
    .pkt_prog_label, .wr_page_ff, .wr_ext_ff, .wr_block8_ff, .wr_label_ff, .wr_row_ff, .disp_row_valid,
    .disp_row, .disp_text_on, .disp_video_on, .row_show_ff, .row_from_ext_ff, .frame_ff);
// ----
// helpers
// ----
function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
endfunction
task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
        bad_count++;
        $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {20'h0, a}; hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata_ff;
endtask
// model of packet routing: {page, ext, block8, label}
function automatic logic [3:0] route(logic [4:0] n, logic ok, logic [1:0] f);
    if (!ok && !(c1[6] && n <= 5'h18)) return 4'h0;
    if (f == 2'h3) return c0[1] ? 4'h1 : 4'h0;
    if (f == 2'h2) return c0[0] ? 4'h2 : 4'h0;
    if (f == 2'h1) return c0[4] ? 4'h0 : 4'h8;
    if (n == 5'h18) return c0[7] ? 4'h8 : (c1[7] ? 4'h0 : 4'h4);
    if (n > 5'h18) return c1[7] ? 4'h0 : 4'h4;
    return 4'h8;
endfunction
task automatic step();
    logic [15:0] r;
    logic [4:0] n, dr;
    logic [1:0] f;
    logic [3:0] e;
    r = rnd();
    n = r[0] ? 5'h18 : r[5:1];
    f = r[9:8];
    dr = r[11] ? 5'h18 : r[15:11];
    e = route(n, r[6] | r[7], f);
    @(posedge hclk);
    pkt_valid <= 1'b1; pkt_num <= n; pkt_check_ok <= r[6] | r[7];
    pkt_header_roll <= f == 2'h1; pkt_inventory <= f == 2'h2; pkt_prog_label <= f == 2'h3;
    disp_row_valid <= r[10]; disp_row <= dr; disp_text_on <= r[12] | r[14]; disp_video_on <= r[13];
    @(posedge hclk);
    pkt_valid <= 1'b0;
    #1;
    chk("wr", {wr_page_ff, wr_ext_ff, wr_block8_ff, wr_label_ff}, e);
    if (e != 4'h0) chk("row", wr_row_ff, n);
    if (e != 4'h0) acc_m++;
    else drop_m++;
    disp_m[0] = r[10] && (dr == 5'h18 || !c0[3]);
    disp_m[1] = r[10] && dr == 5'h18 && c0[6];
    disp_m[2] = (r[12] | r[14]) && !c0[2] && !(c0[5] && r[13]);
    chk("show", row_show_ff, disp_m[0]);
    chk("src", row_from_ext_ff, disp_m[1]);
    chk("frame", frame_ff, disp_m[2]);
endtask
// ----
// run
// ----
initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
end
initial begin
    #60000;
    bad_count++;
    give_verdict();
end
initial begin
    {hsel, hwrite, htrans, haddr, hwdata, pkt_valid, pkt_num, pkt_check_ok} = '0;
    {pkt_header_roll, pkt_inventory, pkt_prog_label, disp_row_valid, disp_row, disp_text_on, disp_video_on} = '0;
    bad_count = 0; tests_run = 0; lfsr = 16'h684d; c0 = 8'h00; c1 = 8'h00;
    acc_m = 0;
    drop_m = 0;
    disp_m = 3'h0;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `TCD_OFS_CTRL0, 32'h0);
    chk("ctrl0 reset", rd, 32'h0);
    bus(1'b0, `TCD_OFS_CTRL1, 32'h0);
    chk("ctrl1 reset", rd, 32'h0);
    for (int k = 0; k < 16; k++) begin
        c0 = rnd();
        c1 = rnd() & 8'hc0;
        bus(1'b1, `TCD_OFS_CTRL0, {rnd(), 8'h0, c0});
        bus(1'b1, `TCD_OFS_CTRL1, {16'hffff, rnd()} | c1);
        c1 = c1 | (lfsr[7:0] & 8'hc0);
        bus(1'b0, `TCD_OFS_CTRL0, 32'h0);
        chk("ctrl0", rd, {24'h0, c0});
        bus(1'b0, `TCD_OFS_CTRL1, 32'h0);
        chk("ctrl1", rd, {24'h0, c1});
        repeat (40) step();
        // write pulses have ended here, so only the display bits stand in the status byte
        bus(1'b0, `TCD_OFS_STATUS, 32'h0);
        chk("status", rd, {24'h0, 1'b0, disp_m, 4'h0});
        bus(1'b0, `TCD_OFS_ACC_CNT, 32'h0);
        chk("accepted", rd, acc_m);
        bus(1'b0, `TCD_OFS_DROP_CNT, 32'h0);
        chk("dropped", rd, drop_m);
        bus(1'b1, `TCD_OFS_ACC_CNT, 32'h0);
        bus(1'b1, `TCD_OFS_DROP_CNT, 32'h0);
        acc_m = 0;
        drop_m = 0;
        bus(1'b0, `TCD_OFS_ACC_CNT, 32'h0);
        chk("accepted clear", rd, 32'h0);
    end
    bus(1'b1, 12'h020, 32'hffffffff);
    chk("unmapped", rd, 32'h0);
    bus(1'b0, 12'h020, 32'h0);
    chk("unmapped", rd, 32'h0);
    give_verdict();
end
endmodule
`default_nettype wire
